// ==== design/nfh_pkg.sv ====
// nfh_pkg: constants for the host-side nand flash bus sequencer
// assumes an asynchronous 8-bit nand device and a 100 MHz system clock
package nfh_pkg;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          STROBE_LOW_NS  = 25;
    localparam int          STROBE_HIGH_NS = 15;
    localparam int          STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          COL_BITS       = 12;
    localparam int          ROW_BITS       = 17;
    localparam int          PLANE_ROW_BIT  = 6;
    localparam int          PAGE_BYTES     = 2112;
    localparam int          PAGES_PER_BLK  = 64;
    localparam int          BLOCKS         = 2048;
    localparam logic [7:0]  CMD_READ_SETUP = 8'h00;
    localparam logic [7:0]  CMD_READ_EXEC  = 8'h30;
    localparam logic [7:0]  CMD_CB_READ    = 8'h35;
    localparam logic [7:0]  CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0]  CMD_CB_PROG    = 8'h85;
    localparam logic [7:0]  CMD_PROG_EXEC  = 8'h10;
    localparam logic [7:0]  CMD_CACHE_PROG = 8'h15;
    localparam logic [7:0]  CMD_ERASE_SET  = 8'h60;
    localparam logic [7:0]  CMD_ERASE_EXEC = 8'hD0;
    localparam logic [7:0]  CMD_STATUS     = 8'h70;
    localparam logic [7:0]  CMD_RESET      = 8'hFF;
    localparam logic [2:0]  OP_READ        = 3'h0;
    localparam logic [2:0]  OP_PROG        = 3'h1;
    localparam logic [2:0]  OP_ERASE       = 3'h2;
    localparam logic [2:0]  OP_STATUS      = 3'h3;
    localparam logic [2:0]  OP_RESET       = 3'h4;
    localparam logic [2:0]  OP_CACHE_PROG  = 3'h5;
    localparam logic [2:0]  OP_CB_READ     = 3'h6;
    localparam logic [2:0]  OP_CB_PROG     = 3'h7;
    typedef enum logic [3:0] {
        NFH_IDLE   = 4'h0,
        NFH_CMD1   = 4'h1,
        NFH_ADDR   = 4'h2,
        NFH_DIN    = 4'h3,
        NFH_CMD2   = 4'h4,
        NFH_BUSY   = 4'h5,
        NFH_DOUT   = 4'h6,
        NFH_DONE   = 4'h7
    } nfh_state_t;
endpackage

// ==== design/nfh_fifo.sv ====
// nfh_fifo: synchronous valid/ready fifo for the program data path
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ns
module nfh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk_in,
    input  wire logic             resetn_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    wire              do_wr = wr_valid_in && wr_ready_out;
    wire              do_rd = rd_valid_out && rd_ready_in;
    // ready is registered from the next count so it leaves the block from a flop
    assign count_next   = count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    assign rd_valid_out = (count_reg != '0);
    assign rd_data_out  = mem[rptr_reg];
    always_ff @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wptr_reg] <= wr_data_in;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
            wr_ready_out <= 1'b0;
        end else begin
            if (do_wr) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
            end
            if (do_rd) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
            end
            count_reg <= count_next;
            wr_ready_out <= (count_next != (AW+1)'(DEPTH));
        end
    end
endmodule

// ==== design/nfh_host.sv ====
// nfh_host: host controller driving an asynchronous nand flash over its pins
// assumes pin inputs are synchronous to ref_clk_in; io_bus resolved outside
`timescale 1ns/1ns
module nfh_host
    import nfh_pkg::*;
#(
    parameter int FIFO_DEPTH = 32,
    parameter int LEN_BITS   = 12
) (
    input  wire logic                ref_clk_in,
    input  wire logic                resetn_in,
    input  wire logic                req_valid_in,
    input  wire logic [2:0]          req_op_in,
    input  wire logic [COL_BITS-1:0] req_col_in,
    input  wire logic [ROW_BITS-1:0] req_row_in,
    input  wire logic [LEN_BITS-1:0] req_len_in,
    output logic                     req_ready_out,
    input  wire logic [7:0]          wdata_in,
    input  wire logic                wdata_valid_in,
    output logic                     wdata_ready_out,
    output logic [7:0]               rdata_out,
    output logic                     rdata_valid_out,
    output logic                     done_out,
    output logic                     plane_out,
    output logic                     chip_select_n_out,
    output logic                     command_latch_sel_out,
    output logic                     addr_latch_sel_out,
    output logic                     input_strobe_n_out,
    output logic                     output_strobe_n_out,
    output logic                     program_lock_n_out,
    output logic [7:0]               io_bus_out,
    output logic                     io_bus_oe_out,
    input  wire logic [7:0]          io_bus_in,
    input  wire logic                busy_flag_n_in
);
    localparam int PH_BITS = 4;
    nfh_state_t          state_reg, state_next;
    logic [2:0]          op_reg;
    logic [COL_BITS-1:0] col_reg;
    logic [ROW_BITS-1:0] row_reg;
    logic [LEN_BITS-1:0] left_reg;
    logic [2:0]          acyc_reg;
    logic [PH_BITS-1:0]  ph_reg;
    logic                ph_last;
    logic [7:0]          fifo_data;
    logic                fifo_valid;
    logic                fifo_take;

    function automatic logic [7:0] addr_byte(input logic [2:0] idx,
                                             input logic [COL_BITS-1:0] col,
                                             input logic [ROW_BITS-1:0] row);
        case (idx)
            3'h0:    addr_byte = col[7:0];
            3'h1:    addr_byte = {4'h0, col[11:8]};
            3'h2:    addr_byte = row[7:0];
            3'h3:    addr_byte = row[15:8];
            default: addr_byte = {7'h00, row[16]};
        endcase
    endfunction

    function automatic logic [7:0] setup_cmd(input logic [2:0] op);
        case (op)
            OP_READ, OP_CB_READ:    setup_cmd = CMD_READ_SETUP;
            OP_PROG, OP_CACHE_PROG: setup_cmd = CMD_PROG_SETUP;
            OP_CB_PROG:             setup_cmd = CMD_CB_PROG;
            OP_ERASE:               setup_cmd = CMD_ERASE_SET;
            OP_STATUS:              setup_cmd = CMD_STATUS;
            default:                setup_cmd = CMD_RESET;
        endcase
    endfunction

    wire [7:0] exec_cmd = (op_reg == OP_READ)       ? CMD_READ_EXEC :
                          (op_reg == OP_CB_READ)    ? CMD_CB_READ :
                          (op_reg == OP_ERASE)      ? CMD_ERASE_EXEC :
                          (op_reg == OP_CACHE_PROG) ? CMD_CACHE_PROG : CMD_PROG_EXEC;
    // erase sends row only; single-cycle commands send no address
    wire [2:0] acyc_first = (req_op_in == OP_ERASE) ? 3'h2 : 3'h0;
    wire       single_cmd = (op_reg == OP_STATUS) || (op_reg == OP_RESET);
    wire       is_prog    = (op_reg == OP_PROG) || (op_reg == OP_CACHE_PROG);
    wire       needs_lock_off = is_prog || (op_reg == OP_ERASE) || (op_reg == OP_CB_PROG);
    wire       writing    = (state_reg == NFH_CMD1) || (state_reg == NFH_ADDR) ||
                            (state_reg == NFH_CMD2) || (state_reg == NFH_DIN);
    // strobe low in first part of each byte phase, high afterwards
    wire       strobe_low = (ph_reg < PH_BITS'(STROBE_LOW_CYC));
    wire       byte_end   = ph_last;
    wire       din_stall  = (state_reg == NFH_DIN) && !fifo_valid && (ph_reg == '0);
    wire       left_zero  = (left_reg == '0);
    // only a request that ready announced is taken, never in the first cycle out of reset
    wire       req_take   = (state_reg == NFH_IDLE) && req_valid_in && req_ready_out;
    // read data sampled while the output strobe is still low; the bus floats once it rises
    wire       rd_sample  = (state_reg == NFH_DOUT) && (ph_reg == PH_BITS'(STROBE_LOW_CYC));
    wire       lock_off   = needs_lock_off && (state_reg != NFH_IDLE) &&
                            (state_reg != NFH_DONE);
    wire [7:0] out_byte   = (state_reg == NFH_CMD1) ? setup_cmd(op_reg) :
                            (state_reg == NFH_CMD2) ? exec_cmd :
                            (state_reg == NFH_ADDR) ? addr_byte(acyc_reg, col_reg, row_reg) :
                            fifo_data;

    assign ph_last   = (ph_reg == PH_BITS'(STROBE_LOW_CYC + STROBE_HIGH_CYC - 1));
    assign fifo_take = (state_reg == NFH_DIN) && byte_end;

    nfh_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .resetn_in    (resetn_in),
        .wr_data_in   (wdata_in),
        .wr_valid_in  (wdata_valid_in),
        .wr_ready_out (wdata_ready_out),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_take)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NFH_IDLE: if (req_take) state_next = NFH_CMD1;
            NFH_CMD1: if (byte_end) state_next = single_cmd ? (op_reg == OP_STATUS ?
                              NFH_DOUT : NFH_BUSY) : NFH_ADDR;
            NFH_ADDR: if (byte_end && acyc_reg == 3'h4) begin
                state_next = (is_prog && !left_zero) ? NFH_DIN : NFH_CMD2;
            end
            NFH_DIN:  if (byte_end && left_reg == LEN_BITS'(1)) state_next = NFH_CMD2;
            NFH_CMD2: if (byte_end) state_next = NFH_BUSY;
            NFH_BUSY: if (busy_flag_n_in && ph_last) begin
                state_next = ((op_reg == OP_READ) && !left_zero) ? NFH_DOUT : NFH_DONE;
            end
            NFH_DOUT: if (byte_end && left_reg <= LEN_BITS'(1)) state_next = NFH_DONE;
            default:  state_next = NFH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            state_reg <= NFH_IDLE;
            ph_reg    <= '0;
        end else begin
            state_reg <= state_next;
            ph_reg    <= (state_next != state_reg || byte_end || din_stall ||
                          state_reg == NFH_IDLE) ? '0 : ph_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            op_reg   <= OP_RESET;
            col_reg  <= '0;
            row_reg  <= '0;
            left_reg <= '0;
            acyc_reg <= '0;
        end else if (req_take) begin
            op_reg   <= req_op_in;
            col_reg  <= req_col_in;
            row_reg  <= req_row_in;
            left_reg <= (req_op_in == OP_STATUS) ? LEN_BITS'(1) : req_len_in;
            acyc_reg <= acyc_first;
        end else if (byte_end) begin
            if (state_reg == NFH_ADDR) acyc_reg <= acyc_reg + 3'h1;
            if (state_reg == NFH_DIN || state_reg == NFH_DOUT) begin
                left_reg <= left_reg - 1'b1;
                col_reg  <= col_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            chip_select_n_out     <= 1'b1;
            command_latch_sel_out <= 1'b0;
            addr_latch_sel_out    <= 1'b0;
            input_strobe_n_out    <= 1'b1;
            output_strobe_n_out   <= 1'b1;
            program_lock_n_out    <= 1'b0;
            io_bus_out            <= 8'h00;
            io_bus_oe_out         <= 1'b0;
            rdata_out             <= 8'h00;
            rdata_valid_out       <= 1'b0;
            done_out              <= 1'b0;
            plane_out             <= 1'b0;
            req_ready_out         <= 1'b0;
        end else begin
            // select held low through busy: deselect would not end the operation
            chip_select_n_out     <= (state_reg == NFH_IDLE) || (state_reg == NFH_DONE);
            command_latch_sel_out <= (state_reg == NFH_CMD1) || (state_reg == NFH_CMD2);
            addr_latch_sel_out    <= (state_reg == NFH_ADDR);
            input_strobe_n_out    <= !(writing && strobe_low && !din_stall);
            output_strobe_n_out   <= !((state_reg == NFH_DOUT) && strobe_low);
            program_lock_n_out    <= lock_off;
            io_bus_out            <= out_byte;
            io_bus_oe_out         <= writing;
            rdata_valid_out       <= (state_reg == NFH_DOUT) && byte_end;
            rdata_out             <= rd_sample ? io_bus_in : rdata_out;
            done_out              <= (state_reg == NFH_DONE);
            plane_out             <= row_reg[PLANE_ROW_BIT];
            req_ready_out         <= (state_next == NFH_IDLE);
        end
    end
endmodule

// ==== test/nfh_host_monitor.sv ====
// nfh_host_monitor: pin timing checks on the nand host sequencer
// assumes it is bound onto nfh_host and sees only its ports
`timescale 1ns/1ns
module nfh_host_monitor (
    input wire logic       ref_clk_in,
    input wire logic       resetn_in,
    input wire logic       req_ready_out,
    input wire logic       rdata_valid_out,
    input wire logic       chip_select_n_out,
    input wire logic       command_latch_sel_out,
    input wire logic       addr_latch_sel_out,
    input wire logic       input_strobe_n_out,
    input wire logic       output_strobe_n_out,
    input wire logic       program_lock_n_out,
    input wire logic [7:0] io_bus_out,
    input wire logic       io_bus_oe_out,
    input wire logic       busy_flag_n_in
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    a_cs_on_write: assert property (!input_strobe_n_out |-> !chip_select_n_out)
        else $error("strobe without select");
    a_one_latch: assert property (!(command_latch_sel_out && addr_latch_sel_out))
        else $error("both latch selects high");
    a_write_drive: assert property (!input_strobe_n_out |-> io_bus_oe_out)
        else $error("write strobe with bus released");
    a_read_float: assert property (!output_strobe_n_out |-> !io_bus_oe_out)
        else $error("host drives during read");
    a_hold_rise: assert property ($rose(input_strobe_n_out) |-> $stable(io_bus_out)
        && $stable(command_latch_sel_out) && $stable(addr_latch_sel_out))
        else $error("bus moved at strobe rise");
    a_write_width: assert property ($fell(input_strobe_n_out) |->
        !input_strobe_n_out [*3] ##1 input_strobe_n_out) else $error("bad write width");
    a_read_width: assert property ($fell(output_strobe_n_out) |->
        !output_strobe_n_out [*3] ##1 output_strobe_n_out) else $error("bad read width");
    a_busy_quiet: assert property (!busy_flag_n_in |-> input_strobe_n_out
        && output_strobe_n_out && !chip_select_n_out) else $error("bus active while busy");
    a_lock_idle: assert property (req_ready_out |-> !program_lock_n_out)
        else $error("lock released while idle");
    a_byte_gap: assert property (rdata_valid_out |=> !rdata_valid_out [*3])
        else $error("read bytes too close");
endmodule

// ==== test/nfh_flash_model.sv ====
// nfh_flash_model: behavioural nand device seen from its pins
// assumes io_bus is resolved by the bench; one page register stands for the array
`timescale 1ns/1ns
module nfh_flash_model
    import nfh_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        command_latch_sel_in,
    input  wire logic        addr_latch_sel_in,
    input  wire logic        input_strobe_n_in,
    input  wire logic        output_strobe_n_in,
    input  wire logic        program_lock_n_in,
    input  wire logic [7:0]  io_bus_in,
    input  wire logic [9:0]  busy_len_in,
    output logic [7:0]       io_bus_out,
    output logic             io_bus_oe_out,
    output logic             busy_flag_n_out,
    output logic [7:0]       cmd_out = 8'h00,
    output logic [11:0]      col_out = 12'h000,
    output logic [16:0]      row_out = 17'h00000,
    output logic [7:0]       hv_ops_out = 8'h00
);
    logic [7:0] page [0:4095];
    logic [2:0] n_addr = 3'h0;
    logic [9:0] busy_cnt = 10'h000;
    logic       kick = 1'b0;
    logic       kick_q = 1'b0;
    wire  [2:0] slot = n_addr + ((cmd_out == CMD_ERASE_SET) ? 3'h2 : 3'h0);
    wire        hv = (io_bus_in == CMD_PROG_EXEC) || (io_bus_in == CMD_CACHE_PROG)
                     || (io_bus_in == CMD_ERASE_EXEC);
    wire        rd = (io_bus_in == CMD_READ_EXEC) || (io_bus_in == CMD_CB_READ);
    initial begin
        for (int i = 0; i < 4096; i++) page[i] = 8'(i) ^ 8'h5A;
    end
    // one process for both strobes, so the column counter has a single writer
    always @(posedge input_strobe_n_in or negedge output_strobe_n_in) begin
        if (!chip_select_n_in && !output_strobe_n_in) begin
            io_bus_out <= (cmd_out == CMD_STATUS) ?
                {program_lock_n_in, busy_flag_n_out, 6'h00} : page[col_out];
            col_out <= col_out + 12'h001;
        end else if (!chip_select_n_in && command_latch_sel_in) begin
            cmd_out <= io_bus_in;
            n_addr <= 3'h0;
            if ((hv && program_lock_n_in) || rd) kick <= ~kick;
            if (hv && program_lock_n_in) hv_ops_out <= hv_ops_out + 8'h01;
        end else if (!chip_select_n_in && addr_latch_sel_in) begin
            case (slot)
                3'h0: col_out[7:0] <= io_bus_in;
                3'h1: col_out[11:8] <= io_bus_in[3:0];
                3'h2: row_out[7:0] <= io_bus_in;
                3'h3: row_out[15:8] <= io_bus_in;
                3'h4: row_out[16] <= io_bus_in[0];
                default: ;
            endcase
            if (slot < 3'h5) n_addr <= n_addr + 3'h1;
        end else if (!chip_select_n_in) begin
            page[col_out] <= io_bus_in;
            col_out <= col_out + 12'h001;
        end
    end
    // busy counts on regardless of chip select, as the real part ignores deselect
    always @(posedge ref_clk_in) begin
        kick_q <= kick;
        if (kick != kick_q) busy_cnt <= busy_len_in;
        else if (busy_cnt != 10'h000) busy_cnt <= busy_cnt - 10'h001;
    end
    assign busy_flag_n_out = (busy_cnt == 10'h000);
    assign io_bus_oe_out = !chip_select_n_in && !output_strobe_n_in;
endmodule

// ==== test/nfh_host_tb_top.sv ====
// nfh_host_tb_top: self-checking bench for the nand host sequencer
// assumes the flash model stands on the pins; the bench resolves io_bus
`timescale 1ns/1ns
module nfh_host_tb_top
    import nfh_pkg::*;
;
    logic        ref_clk_in = 1'b0, resetn_in = 1'b0, req_valid_in = 1'b0;
    logic        wdata_valid_in = 1'b0;
    logic [2:0]  req_op_in = 3'h0;
    logic [11:0] req_col_in = 12'h000, req_len_in = 12'h000, cp, ln;
    logic [16:0] req_row_in = 17'h00000, row;
    logic [7:0]  wdata_in = 8'h00, io_last = 8'h00, pd [0:39];
    logic [9:0]  busy_len = 10'h002;
    wire  [7:0]  rdata_out, io_bus_out, io_bus_in, dev_io, m_cmd, m_hv;
    wire  [11:0] m_col;
    wire  [16:0] m_row;
    wire         req_ready_out, wdata_ready_out, rdata_valid_out, done_out, plane_out;
    wire         chip_select_n_out, command_latch_sel_out, addr_latch_sel_out, dev_oe;
    wire         input_strobe_n_out, output_strobe_n_out, program_lock_n_out;
    wire         io_bus_oe_out, busy_flag_n_in;
    logic [7:0]  exp_q [$];
    int          n_fail = 0, n_compared = 0, n_cyc = 0, seed = 32190, exp_hv = 0;
    logic [2:0]  t_op [6] = '{OP_ERASE, OP_STATUS, OP_RESET, OP_CACHE_PROG, OP_CB_READ,
                              OP_CB_PROG};
    logic [7:0]  t_cmd [6] = '{CMD_ERASE_EXEC, CMD_STATUS, CMD_RESET, CMD_CACHE_PROG,
                               CMD_CB_READ, CMD_PROG_EXEC};
    logic [5:0]  t_hv = 6'b101001;
    nfh_host u_nfh_host (.ref_clk_in, .resetn_in, .req_valid_in, .req_op_in, .req_col_in,
        .req_row_in, .req_len_in, .req_ready_out, .wdata_in, .wdata_valid_in,
        .wdata_ready_out, .rdata_out, .rdata_valid_out, .done_out, .plane_out,
        .chip_select_n_out, .command_latch_sel_out, .addr_latch_sel_out,
        .input_strobe_n_out, .output_strobe_n_out, .program_lock_n_out, .io_bus_out,
        .io_bus_oe_out, .io_bus_in, .busy_flag_n_in);
    nfh_flash_model u_nfh_flash_model (.ref_clk_in(ref_clk_in),
        .chip_select_n_in(chip_select_n_out), .command_latch_sel_in(command_latch_sel_out),
        .addr_latch_sel_in(addr_latch_sel_out), .input_strobe_n_in(input_strobe_n_out),
        .output_strobe_n_in(output_strobe_n_out), .program_lock_n_in(program_lock_n_out),
        .io_bus_in(io_bus_in), .busy_len_in(busy_len), .io_bus_out(dev_io),
        .io_bus_oe_out(dev_oe), .busy_flag_n_out(busy_flag_n_in), .cmd_out(m_cmd),
        .col_out(m_col), .row_out(m_row), .hv_ops_out(m_hv));
    // a released bus shows the inverse of its last level, never a kind constant
    assign io_bus_in = io_bus_oe_out ? io_bus_out : (dev_oe ? dev_io : ~io_last);
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic finish_test();
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // valid stays up between bytes; the caller lowers it after the last one
    task automatic push_byte(input logic [7:0] d);
        int k = 0;
        wdata_in = d;
        wdata_valid_in = 1'b1;
        do begin
            @(posedge ref_clk_in);
            k++;
        end while (wdata_ready_out !== 1'b1 && k < 3000);
        #1;
    endtask
    task automatic do_op(input logic [2:0] op, input logic [11:0] col,
                         input logic [16:0] r, input logic [11:0] len);
        int k = 0;
        req_op_in = op;
        req_col_in = col;
        req_row_in = r;
        req_len_in = len;
        req_valid_in = 1'b1;
        do @(posedge ref_clk_in); while (req_ready_out !== 1'b1);
        #1 req_valid_in = 1'b0;
        do begin
            @(posedge ref_clk_in);
            k++;
        end while (done_out !== 1'b1 && k < 5000);
        #1;
        chk(k < 5000, 1'b1);
    endtask
    // the device column ends past the start by one per data byte moved
    task automatic check_addr(input logic [7:0] cmd, input logic wc, input logic wr,
                              input logic [11:0] adv);
        chk(m_cmd, cmd);
        chk(m_hv, exp_hv);
        if (wc) chk(m_col, cp + adv);
        if (wr) chk(m_row, row);
    endtask
    always @(posedge ref_clk_in) begin
        io_last <= io_bus_in;
        n_cyc <= n_cyc + 1;
        if (rdata_valid_out === 1'b1) begin
            if (exp_q.size() == 0) chk(rdata_out, 32'hFFFF_FFFF);
            else chk(rdata_out, exp_q.pop_front());
        end
        if (n_cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_in);
        #1 resetn_in = 1'b1;
        cp = 12'h3FF & 12'($random(seed));
        row = 17'($random(seed));
        for (int i = 0; i < 6; i++) exp_q.push_back(8'(cp + i) ^ 8'h5A);
        do_op(OP_READ, cp, row, 12'd6);
        check_addr(CMD_READ_EXEC, 1'b1, 1'b1, 12'd6);
        chk(plane_out, row[6]);
        busy_len = 10'd300;
        cp = 12'h3FF & 12'($random(seed));
        for (int i = 0; i < 40; i++) pd[i] = 8'($random(seed));
        for (int i = 0; i < 32; i++) push_byte(pd[i]);
        chk(wdata_ready_out, 1'b0);
        exp_hv++;
        fork
            do_op(OP_PROG, cp, row, 12'd40);
            begin
                for (int i = 32; i < 40; i++) push_byte(pd[i]);
                wdata_valid_in = 1'b0;
            end
        join
        check_addr(CMD_PROG_EXEC, 1'b1, 1'b1, 12'd40);
        busy_len = 10'd2;
        for (int i = 0; i < 40; i++) exp_q.push_back(pd[i]);
        do_op(OP_READ, cp, row, 12'd40);
        for (int i = 0; i < 4; i++) push_byte(8'(i));
        wdata_valid_in = 1'b0;
        for (int j = 0; j < 6; j++) begin
            cp = 12'h3FF & 12'($random(seed));
            row = 17'($random(seed));
            if (t_op[j] == OP_STATUS) exp_q.push_back(8'h40);
            exp_hv += t_hv[j];
            ln = (t_op[j] == OP_CACHE_PROG) ? 12'd4 : 12'd0;
            do_op(t_op[j], cp, row, ln);
            check_addr(t_cmd[j], t_op[j] > OP_RESET, j != 1 && j != 2, ln);
        end
        chk(exp_q.size(), 0);
        finish_test();
    end
endmodule
bind nfh_host nfh_host_monitor u_nfh_host_monitor (.ref_clk_in, .resetn_in, .req_ready_out,
    .rdata_valid_out, .chip_select_n_out, .command_latch_sel_out, .addr_latch_sel_out,
    .input_strobe_n_out, .output_strobe_n_out, .program_lock_n_out, .io_bus_out,
    .io_bus_oe_out, .busy_flag_n_in);
